/* logic/adt_consts.svh */
// Offsets, field positions, reset values and timing counts of the block.
`ifndef ADT_CONSTS_SVH
`define ADT_CONSTS_SVH

// Register byte offsets on the APB.
`define ADT_OFF_SC1    8'h00
`define ADT_OFF_SC2    8'h04
`define ADT_OFF_RESH   8'h08
`define ADT_OFF_RESL   8'h0c
`define ADT_OFF_CVH    8'h10
`define ADT_OFF_CVL    8'h14
`define ADT_OFF_CFG    8'h18
`define ADT_OFF_PIN1   8'h1c
`define ADT_OFF_PIN2   8'h20
`define ADT_OFF_PIN3   8'h24
`define ADT_OFF_WAKE   8'h28
`define ADT_OFF_STS    8'h2c
`define ADT_OFF_MASK   8'h30

// Field positions.
`define ADT_SC1_DONE   7
`define ADT_SC2_ACT    7
`define ADT_STS_DONE   0
`define ADT_STS_MISS   1

// Reset values.
`define ADT_SC1_RST    7'h1f
`define ADT_SC2_RST    3'h0
`define ADT_CFG_RST    5'h00
`define ADT_WAKE_RST   4'h0
`define ADT_CH_OFF     5'h1f
`define ADT_MODE_10BIT 2'h2

// Timing.
`define ADT_SHORT_SAMPLE 4
`define ADT_LONG_SAMPLE  24
`define ADT_PCLK_HZ      125000000
`define ADT_LPO_HZ       32000
`define ADT_LPO_DIV      (`ADT_PCLK_HZ / `ADT_LPO_HZ)
`define ADT_WAKE_BASE    4

`endif

/* logic/adt_pkg.sv */
// Types shared by the converter control block.
`default_nettype none

package adt_pkg;

   typedef enum logic [1:0] {adt_idle, adt_sample, adt_convert} adt_state_t;

   typedef struct packed {
      logic       aien;
      logic       cont;
      logic [4:0] ch;
   } adt_sc1_t;

   typedef struct packed {
      logic hw_trig_en;
      logic cmp_en;
      logic cmp_ge;
   } adt_sc2_t;

   typedef struct packed {
      logic       long_smp;
      logic [1:0] mode;
      logic [1:0] clk_sel;
   } adt_cfg_t;

   typedef struct packed {
      logic       src_int;
      logic [2:0] period_sel;
   } adt_wake_t;

endpackage : adt_pkg

`default_nettype wire

/* logic/adt_periodic_wakeup_counter.sv */
// Periodic wakeup counter, held at zero while the period select is zero, that makes the conversion trigger.
`default_nettype none
`include "adt_consts.svh"

module adt_periodic_wakeup_counter
   import adt_pkg::*;
#(
   parameter int BASE = `ADT_WAKE_BASE
)
(
   // Clock and reset.
   input  wire logic      pclk,
   input  wire logic      presetn,
   // Configuration and reference tick.
   input  wire adt_wake_t cfg,
   input  wire logic      oscillator_reference_clock_tick,
   // Overflow pulse.
   output var  logic      hw_conversion_trigger
);

   localparam int CW      = BASE + 7;
   localparam int LPO_DIV = `ADT_LPO_DIV;

   logic [11:0]   lpo_cnt;
   logic          lpo_tick;
   logic [CW-1:0] cnt;
   logic          src_tick;
   logic          run;
   logic [CW-1:0] top;
   logic          wrap;

   // The own source is a divider, so it needs no clock of its own.
   assign src_tick = cfg.src_int ? lpo_tick
                                 : oscillator_reference_clock_tick;
   assign run  = cfg.period_sel != 3'h0;
   assign top  = CW'((CW'(1) << (BASE + int'(cfg.period_sel) - 1)) - 1);
   // A shrunk period wraps at once instead of running through the top.
   assign wrap = src_tick & (cnt >= top);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lpo_cnt  <= 12'h000;
         lpo_tick <= 1'b0;
      end
      else
      begin
         lpo_tick <= lpo_cnt == 12'(LPO_DIV - 1);
         lpo_cnt  <= (lpo_cnt == 12'(LPO_DIV - 1)) ? 12'h000
                                                   : lpo_cnt + 12'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt                   <= '0;
         hw_conversion_trigger <= 1'b0;
      end
      else
      begin
         hw_conversion_trigger <= run & wrap;
         if (!run)
            cnt <= '0;
         else if (src_tick)
            cnt <= wrap ? '0 : cnt + CW'(1);
      end
   end

endmodule : adt_periodic_wakeup_counter

`default_nettype wire

/* logic/adt_ctrl.sv */
// Trigger, mode control, compare and APB registers of a 10-bit SAR converter.
//
// Local design decisions: the APB interface to the registers and the address map.
`default_nettype none
`include "adt_consts.svh"

module adt_ctrl
   import adt_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset.
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave.
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output var  logic [31:0]       prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   // Clock ticks and power mode.
   input  wire logic              oscillator_reference_clock_tick,
   input  wire logic              local_async_clock_tick,
   input  wire logic              mode_stop3,
   input  wire logic              low_voltage_detect_stop_enable,
   // Analog front end.
   input  wire logic              compare_high,
   output var  logic              converter_on,
   output var  logic              sample_en,
   output var  logic              long_sample,
   output var  logic [9:0]        dac_code,
   output var  logic [4:0]        input_channel_select,
   output var  logic [7:0]        analog_pin_enable_first,
   // Interrupt.
   output var  logic              irq
);

   adt_sc1_t   sc1;
   adt_sc2_t   sc2;
   adt_cfg_t   cfg;
   adt_wake_t  wake;
   logic       conversion_done_flag;
   logic [9:0] cmpv;
   logic [9:0] result;
   logic [1:0] sts;
   logic [1:0] mask;
   logic [1:0] next_sts;
   adt_state_t state;
   adt_state_t next_state;
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic [3:0] bitpos;
   logic [3:0] next_bit;
   logic [9:0] sar;
   logic [9:0] next_sar;
   logic       div2;
   logic       hw_conversion_trigger;

   // Bus decode.
   logic setup;
   logic acc;
   logic wr_fire;
   logic rd_fire;
   logic aligned;
   assign setup   = psel & ~penable;
   assign acc     = psel & penable & pready;
   assign wr_fire = acc & pwrite & pstrb[0];
   assign rd_fire = acc & ~pwrite;
   assign aligned = paddr[1:0] == 2'b00;

   logic hit_sc1;
   logic hit_sc2;
   logic hit_resh;
   logic hit_resl;
   logic hit_cvh;
   logic hit_cvl;
   logic hit_cfg;
   logic hit_pin1;
   logic hit_pin23;
   logic hit_wake;
   logic hit_sts;
   logic hit_mask;
   logic mapped;
   assign hit_sc1   = aligned & (paddr == ADDR_W'(`ADT_OFF_SC1));
   assign hit_sc2   = aligned & (paddr == ADDR_W'(`ADT_OFF_SC2));
   assign hit_resh  = aligned & (paddr == ADDR_W'(`ADT_OFF_RESH));
   assign hit_resl  = aligned & (paddr == ADDR_W'(`ADT_OFF_RESL));
   assign hit_cvh   = aligned & (paddr == ADDR_W'(`ADT_OFF_CVH));
   assign hit_cvl   = aligned & (paddr == ADDR_W'(`ADT_OFF_CVL));
   assign hit_cfg   = aligned & (paddr == ADDR_W'(`ADT_OFF_CFG));
   assign hit_pin1  = aligned & (paddr == ADDR_W'(`ADT_OFF_PIN1));
   // The second and third pin enable slots read zero and hold nothing.
   assign hit_pin23 = aligned & ((paddr == ADDR_W'(`ADT_OFF_PIN2))
                              | (paddr == ADDR_W'(`ADT_OFF_PIN3)));
   assign hit_wake  = aligned & (paddr == ADDR_W'(`ADT_OFF_WAKE));
   assign hit_sts   = aligned & (paddr == ADDR_W'(`ADT_OFF_STS));
   assign hit_mask  = aligned & (paddr == ADDR_W'(`ADT_OFF_MASK));
   assign mapped    = hit_sc1 | hit_sc2 | hit_resh | hit_resl | hit_cvh
                    | hit_cvl | hit_cfg | hit_pin1 | hit_pin23 | hit_wake
                    | hit_sts | hit_mask;

   logic wr_sc1;
   logic rd_resl;
   assign wr_sc1  = wr_fire & hit_sc1;
   assign rd_resl = rd_fire & hit_resl;

   // Read selection.
   logic [7:0] rd_val;
   assign rd_val = ({8{hit_sc1}}  & {conversion_done_flag, sc1})
                 | ({8{hit_sc2}}  & {state != adt_idle, sc2, 4'h0})
                 | ({8{hit_resh}} & {6'h00, result[9:8]})
                 | ({8{hit_resl}} & result[7:0])
                 | ({8{hit_cvh}}  & {6'h00, cmpv[9:8]})
                 | ({8{hit_cvl}}  & cmpv[7:0])
                 | ({8{hit_cfg}}  & {3'h0, cfg})
                 | ({8{hit_pin1}} & analog_pin_enable_first)
                 | ({8{hit_wake}} & {4'h0, wake})
                 | ({8{hit_sts}}  & {6'h00, sts})
                 | ({8{hit_mask}} & {6'h00, mask});

   // Trigger source: the wakeup counter, kept alive in every power mode.
   adt_periodic_wakeup_counter u_wakeup
   (
      .pclk                            (pclk),
      .presetn                         (presetn),
      .cfg                             (wake),
      .oscillator_reference_clock_tick (oscillator_reference_clock_tick),
      .hw_conversion_trigger           (hw_conversion_trigger)
   );

   // Converter clock. The bus clock is gone in stop3, so only the local
   // clock can advance a conversion there; the alternate input is absent.
   logic run_ok;
   logic bus_tick;
   logic adck_tick;
   logic sel_tick;
   assign run_ok   = ~mode_stop3 | low_voltage_detect_stop_enable;
   assign bus_tick = ~mode_stop3;
   assign sel_tick = (cfg.clk_sel == 2'h0) ? bus_tick
                   : (cfg.clk_sel == 2'h1) ? bus_tick & div2
                   : local_async_clock_tick;
   assign adck_tick = run_ok & sel_tick;

   // Start, abort and trigger decisions.
   logic ch_off;
   logic hw_trig;
   logic sw_start;
   logic hw_start;
   logic abort;
   logic missed;
   assign ch_off   = sc1.ch == `ADT_CH_OFF;
   assign hw_trig  = hw_conversion_trigger & sc2.hw_trig_en & ~ch_off
                   & run_ok;
   // A write in stop3 without the stop enable must not start anything.
   assign sw_start = wr_sc1 & (pwdata[4:0] != `ADT_CH_OFF) & run_ok
                   & ~sc2.hw_trig_en;
   assign hw_start = hw_trig & (state == adt_idle) & ~wr_sc1;
   assign abort    = wr_sc1 | ~run_ok;
   // A trigger that lands on a busy single conversion is dropped.
   assign missed   = hw_trig & (state != adt_idle) & ~sc1.cont;

   // Successive approximation step.
   logic [9:0] trial;
   logic [9:0] sar_keep;
   logic [3:0] lsb;
   logic [4:0] samp_last;
   logic       ten_bit;
   assign ten_bit   = cfg.mode == `ADT_MODE_10BIT;
   assign lsb       = ten_bit ? 4'h0 : 4'h2;
   assign trial     = 10'h001 << bitpos;
   assign sar_keep  = compare_high ? sar : (sar & ~trial);
   assign samp_last = cfg.long_smp ? 5'(`ADT_LONG_SAMPLE - 1)
                                   : 5'(`ADT_SHORT_SAMPLE - 1);

   logic conv_last;
   always_comb
   begin
      next_state = state;
      next_cnt   = cnt;
      next_bit   = bitpos;
      next_sar   = sar;
      conv_last  = 1'b0;
      case (state)
         adt_idle:
         begin
            next_cnt = 5'h00;
         end
         adt_sample:
         begin
            if (adck_tick)
            begin
               if (cnt == samp_last)
               begin
                  next_state = adt_convert;
                  next_cnt   = 5'h00;
                  next_bit   = 4'h9;
                  next_sar   = 10'h200;
               end
               else
                  next_cnt = cnt + 5'h01;
            end
         end
         adt_convert:
         begin
            if (adck_tick)
            begin
               next_sar = sar_keep;
               if (bitpos == lsb)
               begin
                  conv_last  = 1'b1;
                  next_state = adt_idle;
               end
               else
               begin
                  next_bit = bitpos - 4'h1;
                  next_sar = sar_keep | (10'h001 << (bitpos - 4'h1));
               end
            end
         end
         default:
         begin
            next_state = adt_idle;
         end
      endcase
      if (conv_last & sc1.cont & ~ch_off)
      begin
         next_state = adt_sample;
         next_cnt   = 5'h00;
      end
      if (abort)
         next_state = adt_idle;
      if (sw_start | hw_start)
      begin
         next_state = adt_sample;
         next_cnt   = 5'h00;
      end
   end

   // Result, compare and completion.
   logic [9:0] final_val;
   logic       cmp_true;
   logic       done_set;
   logic       next_done;
   assign final_val = ten_bit ? sar_keep : {2'b00, sar_keep[9:2]};
   assign cmp_true  = sc2.cmp_ge ? (final_val >= cmpv)
                                 : (final_val < cmpv);
   // An aborting write discards the conversion that ends with it.
   assign done_set  = conv_last & ~abort
                    & (~sc2.cmp_en | cmp_true);
   assign next_done = done_set
                    | (conversion_done_flag & ~wr_sc1 & ~rd_resl);

   // Sticky events, write one to clear; a new event beats the clear.
   logic [1:0] sts_set;
   logic [1:0] sts_clr;
   assign sts_set = {missed, done_set};
   assign sts_clr = (wr_fire & hit_sts) ? pwdata[1:0] : 2'b00;
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_sts
         assign next_sts[gi] = sts_set[gi] | (sts[gi] & ~sts_clr[gi]);
      end
   endgenerate

   assign input_channel_select = sc1.ch;
   assign dac_code             = sar;
   assign long_sample          = cfg.long_smp;

   // Software registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sc1                     <= `ADT_SC1_RST;
         sc2                     <= `ADT_SC2_RST;
         cfg                     <= `ADT_CFG_RST;
         wake                    <= `ADT_WAKE_RST;
         cmpv                    <= 10'h000;
         analog_pin_enable_first <= 8'h00;
         mask                    <= 2'b00;
      end
      else if (wr_fire)
      begin
         if (hit_sc1)
            sc1 <= pwdata[6:0];
         if (hit_sc2)
            sc2 <= pwdata[6:4];
         if (hit_cfg)
            cfg <= pwdata[4:0];
         if (hit_wake)
            wake <= pwdata[3:0];
         if (hit_cvh)
            cmpv[9:8] <= pwdata[1:0];
         if (hit_cvl)
            cmpv[7:0] <= pwdata[7:0];
         if (hit_pin1)
            analog_pin_enable_first <= pwdata[7:0];
         if (hit_mask)
            mask <= pwdata[1:0];
      end
   end

   // Converter state, flags and interrupt.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state                <= adt_idle;
         cnt                  <= 5'h00;
         bitpos               <= 4'h0;
         sar                  <= 10'h000;
         div2                 <= 1'b0;
         result               <= 10'h000;
         conversion_done_flag <= 1'b0;
         sts                  <= 2'b00;
         converter_on         <= 1'b0;
         sample_en            <= 1'b0;
         irq                  <= 1'b0;
      end
      else
      begin
         state                <= next_state;
         cnt                  <= next_cnt;
         bitpos               <= next_bit;
         sar                  <= next_sar;
         div2                 <= ~div2;
         conversion_done_flag <= next_done;
         sts                  <= next_sts;
         converter_on         <= next_state != adt_idle;
         sample_en            <= next_state == adt_sample;
         irq <= |(next_sts & mask & {1'b1, sc1.aien});
         if (done_set)
            result <= final_val;
      end
   end

   // APB answer: ready one cycle after setup, with data caught at setup.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         if (setup)
            prdata <= {24'h00_0000, rd_val};
      end
   end

endmodule : adt_ctrl

`default_nettype wire

/* bench/adt_ctrl_asserts.sv */
// Port-level checks of the converter control block, bound to its top.
`default_nettype none

module adt_ctrl_asserts
   import adt_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset.
   input wire logic              pclk,
   input wire logic              presetn,
   // APB slave.
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // Converter side.
   input wire logic              oscillator_reference_clock_tick,
   input wire logic              local_async_clock_tick,
   input wire logic              mode_stop3,
   input wire logic              low_voltage_detect_stop_enable,
   input wire logic              compare_high,
   input wire logic              converter_on,
   input wire logic              sample_en,
   input wire logic              long_sample,
   input wire logic [9:0]        dac_code,
   input wire logic [4:0]        input_channel_select,
   input wire logic [7:0]        analog_pin_enable_first,
   input wire logic              irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   wire logic wr_tk = psel && penable && pready && pwrite && pstrb[0];
   wire logic sc1_wr = wr_tk && (paddr == '0);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_off_write;
      sc1_wr && (pwdata[4:0] == 5'h1f);
   endsequence
   sequence s_trials_begin;
      $fell(sample_en) && converter_on;
   endsequence

   a_ready_after_setup:
      assert property (s_setup |=> pready) else $error("late ready");
   a_ready_one_cycle:
      assert property (pready |=> !pready) else $error("ready too long");
   a_error_with_ready:
      assert property (pslverr |-> pready) else $error("stray error");
   a_read_upper_zero:
      assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_start_needs_channel:
      assert property ($rose(converter_on) |-> input_channel_select != 5'h1f)
      else $error("start while off");
   a_off_no_extra:
      assert property (s_off_write |=> !converter_on [*8])
      else $error("conversion after off");
   a_stop3_idle:
      assert property ((mode_stop3 && !low_voltage_detect_stop_enable) [*3]
         |-> !converter_on) else $error("runs in stop3");
   a_sample_in_on:
      assert property (sample_en |-> converter_on) else $error("sample idle");
   a_trial_msb_first:
      assert property (s_trials_begin |-> dac_code == 10'h200)
      else $error("first trial wrong");
   a_pin_by_write:
      assert property (!$stable(analog_pin_enable_first) |->
         $past(wr_tk && paddr == ADDR_W'(8'h1c))) else $error("pin changed");
   a_channel_by_write:
      assert property (!$stable(input_channel_select) |-> $past(sc1_wr))
      else $error("channel changed");
endmodule : adt_ctrl_asserts

bind adt_ctrl adt_ctrl_asserts #(.ADDR_W(ADDR_W)) i_adt_ctrl_asserts (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .prdata, .pready, .pslverr, .oscillator_reference_clock_tick,
   .local_async_clock_tick, .mode_stop3, .low_voltage_detect_stop_enable,
   .compare_high, .converter_on, .sample_en, .long_sample, .dac_code,
   .input_channel_select, .analog_pin_enable_first, .irq
);

`default_nettype wire

/* bench/adt_afe_model.sv */
// Analog comparator and clock tick source facing the converter control.
`default_nettype none

module adt_afe_model
(
   // Clock and reset.
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Converter side.
   input  wire logic       converter_on,
   input  wire logic [9:0] dac_code,
   input  wire logic [9:0] analog_level,
   output var  logic       compare_high,
   // Clock ticks.
   output var  logic       oscillator_reference_clock_tick,
   output var  logic       local_async_clock_tick
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0] cnt;
   logic       junk;

   // Outside a conversion the comparator wanders, so stale sampling shows.
   assign compare_high = converter_on ? (analog_level >= dac_code)
                                      : junk;
   assign oscillator_reference_clock_tick = (cnt == 2'h1);
   assign local_async_clock_tick = (cnt == 2'h2);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt  <= 2'h0;
         junk <= 1'b0;
      end
      else
      begin
         cnt  <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
         junk <= ~junk;
      end
   end
endmodule : adt_afe_model

`default_nettype wire

/* bench/adt_ctrl_tb.sv */
// Self-checking bench of the converter control block.
`default_nettype none

`define CHK(g, e) \
   begin \
      checks_done++; \
      if ((g) !== (e)) \
      begin \
         bad_count++; \
         $display("CHECK FAILED at %0t: got %0h want %0h", $time, g, e); \
      end \
   end

module adt_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        oscillator_reference_clock_tick;
   logic        local_async_clock_tick;
   logic        mode_stop3;
   logic        low_voltage_detect_stop_enable;
   logic        compare_high;
   logic        converter_on;
   logic        sample_en;
   logic        long_sample;
   logic [9:0]  dac_code;
   logic [4:0]  input_channel_select;
   logic [7:0]  analog_pin_enable_first;
   logic        irq;
   logic [9:0]  analog_level;
   logic [31:0] rdat;
   logic        rerr;
   logic        found;
   int          bad_count;
   int          checks_done;

   adt_ctrl i_adt_ctrl (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .oscillator_reference_clock_tick,
      .local_async_clock_tick, .mode_stop3, .low_voltage_detect_stop_enable,
      .compare_high, .converter_on, .sample_en, .long_sample, .dac_code,
      .input_channel_select, .analog_pin_enable_first, .irq
   );
   adt_afe_model i_adt_afe_model (
      .pclk, .presetn, .converter_on, .dac_code, .analog_level, .compare_high,
      .oscillator_reference_clock_tick, .local_async_clock_tick
   );

   always #4 pclk = ~pclk;

   task automatic summarize();
      $display("checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize

   // One APB transfer; the bus is left idle for a cycle afterwards.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      `CHK(n, 1);
   endtask : apb

   task automatic wait_on(input logic v, input int lim);
      int n;
      n = 0;
      while (converter_on !== v && n < lim)
      begin
         @(posedge pclk);
         n++;
      end
      found = (converter_on === v);
   endtask : wait_on

   task automatic conv(input logic [31:0] sc1);
      apb(1'b1, 8'h00, sc1);
      wait_on(1'b1, 4);
      `CHK(found, 1'b1);
      wait_on(1'b0, 600);
      `CHK(found, 1'b1);
      repeat (2) @(posedge pclk);
   endtask : conv

   initial
   begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      summarize();
   end

   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hf;
      mode_stop3 = 1'b0;
      low_voltage_detect_stop_enable = 1'b0;
      analog_level = 10'h2a5;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(input_channel_select, 5'h1f);
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rdat, 32'h1f);
      apb(1'b1, 8'h1c, 32'ha5);
      apb(1'b0, 8'h1c, 32'h0);
      `CHK(rdat, 32'ha5);
      `CHK(analog_pin_enable_first, 8'ha5);
      // A write without its low byte lane stores nothing.
      pstrb <= 4'h0;
      apb(1'b1, 8'h1c, 32'h5a);
      pstrb <= 4'hf;
      apb(1'b0, 8'h1c, 32'h0);
      `CHK(rdat, 32'ha5);
      for (int r = 8'h20; r <= 8'h24; r += 4)
      begin
         apb(1'b1, 8'(r), 32'hff);
         apb(1'b0, 8'(r), 32'h0);
         `CHK(rdat, 32'h0);
      end
      apb(1'b0, 8'h34, 32'h0);
      `CHK(rerr, 1'b1);
      // Ten-bit single conversion with the interrupt unmasked, then masked.
      apb(1'b1, 8'h18, 32'h08);
      apb(1'b1, 8'h30, 32'h1);
      conv(32'h43);
      `CHK(irq, 1'b1);
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rdat[7], 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      `CHK(rdat, 32'h2);
      apb(1'b0, 8'h0c, 32'h0);
      `CHK(rdat, 32'ha5);
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rdat[7], 1'b0);
      apb(1'b1, 8'h2c, 32'h1);
      @(posedge pclk);
      `CHK(irq, 1'b0);
      apb(1'b1, 8'h30, 32'h0);
      conv(32'h43);
      `CHK(irq, 1'b0);
      apb(1'b1, 8'h30, 32'h1);
      @(posedge pclk);
      `CHK(irq, 1'b1);
      apb(1'b1, 8'h2c, 32'h1);
      // Eight-bit format keeps the top eight trials right-justified.
      apb(1'b1, 8'h18, 32'h00);
      conv(32'h03);
      apb(1'b0, 8'h0c, 32'h0);
      `CHK(rdat, 32'ha9);
      apb(1'b0, 8'h08, 32'h0);
      `CHK(rdat, 32'h0);
      apb(1'b1, 8'h18, 32'h08);
      apb(1'b1, 8'h10, 32'h3);
      apb(1'b1, 8'h14, 32'h0);
      apb(1'b1, 8'h04, 32'h30);
      conv(32'h03);
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rdat[7], 1'b0);
      apb(1'b1, 8'h04, 32'h20);
      conv(32'h03);
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rdat[7], 1'b1);
      apb(1'b1, 8'h04, 32'h00);
      for (int c = 0; c < 4; c++)
      begin
         apb(1'b1, 8'h18, 32'h18 | c);
         conv(c[0] ? 32'h1a : 32'h1b);
         `CHK(long_sample, 1'b1);
         apb(1'b0, 8'h0c, 32'h0);
         `CHK(rdat, 32'ha5);
      end
      for (int c = 0; c < 28; c++)
      begin
         apb(1'b1, 8'h00, c);
         `CHK(input_channel_select, c[4:0]);
      end
      apb(1'b1, 8'h00, 32'h1f);
      repeat (8) @(posedge pclk);
      `CHK(converter_on, 1'b0);
      // Continuous mode stopped by the off channel leaves no extra result.
      apb(1'b1, 8'h18, 32'h08);
      apb(1'b1, 8'h00, 32'h21);
      repeat (60) @(posedge pclk);
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rdat[7], 1'b1);
      wait_on(1'b1, 40);
      `CHK(found, 1'b1);
      apb(1'b1, 8'h00, 32'h1f);
      repeat (40) @(posedge pclk);
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rdat[7], 1'b0);
      mode_stop3 <= 1'b1;
      apb(1'b1, 8'h18, 32'h0b);
      apb(1'b1, 8'h00, 32'h05);
      repeat (200) @(posedge pclk);
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rdat[7], 1'b0);
      low_voltage_detect_stop_enable <= 1'b1;
      conv(32'h05);
      mode_stop3 <= 1'b0;
      low_voltage_detect_stop_enable <= 1'b0;
      // Periodic trigger: stopped at select zero, then an overflow starts an idle converter and one landing on a busy conversion is missed.
      apb(1'b1, 8'h18, 32'h08);
      apb(1'b1, 8'h28, 32'h00);
      apb(1'b1, 8'h04, 32'h40);
      apb(1'b1, 8'h00, 32'h02);
      wait_on(1'b1, 200);
      `CHK(found, 1'b0);
      apb(1'b1, 8'h28, 32'h01);
      wait_on(1'b1, 100);
      `CHK(found, 1'b1);
      wait_on(1'b0, 100);
      wait_on(1'b1, 100);
      `CHK(found, 1'b1);
      apb(1'b1, 8'h18, 32'h1b);
      apb(1'b1, 8'h2c, 32'h3);
      repeat (300) @(posedge pclk);
      apb(1'b0, 8'h2c, 32'h0);
      `CHK(rdat[1], 1'b1);
      summarize();
   end
endmodule : adt_ctrl_tb

`default_nettype wire
